//--- prm_cfg.svh
// Constants for the procedure return and miscellaneous instruction unit
`ifndef PRM_CFG_SVH
`define PRM_CFG_SVH
`define PRM_OP_HALT 8'h00
`define PRM_OP_NOP 8'h01
`define PRM_OP_BRK 8'h03
`define PRM_OP_RETURN 8'h04
`define PRM_OP_INDEX 8'h0A
`define PRM_OP_SBSET 8'hB8
`define PRM_OP_SBCLR 8'hB9
`define PRM_OP_RPOP 8'hBA
`define PRM_OP_RPUSH 8'hBB
`define PRM_OP_RDPSL 8'hDC
`define PRM_OP_BUG_LO 8'hFD
`define PRM_OP_BUG_LO2 8'hFE
`define PRM_OP_BUG_HI 8'hFF
`define PRM_FRAME_OFS 32'h0000_0004
`define PRM_LONG_BYTES 32'h0000_0004
`define PRM_SP_IDX 4'hE
`define PRM_AP_IDX 4'hC
`define PRM_FP_IDX 4'hD
`define PRM_PC_IDX 4'hF
`define PRM_KERNEL_MODE 2'h0
// APB register map
`define PRM_REG_CMD 12'h000
`define PRM_REG_OPA 12'h004
`define PRM_REG_OPB 12'h008
`define PRM_REG_OPC 12'h00C
`define PRM_REG_OPD 12'h010
`define PRM_REG_OPE 12'h014
`define PRM_REG_STATUS 12'h018
`define PRM_REG_RESULT 12'h01C
`define PRM_REG_PSL 12'h020
`define PRM_REG_SP 12'h024
`define PRM_REG_FP 12'h028
`define PRM_REG_AP 12'h02C
`define PRM_REG_PC 12'h030
`define PRM_PSL_RST 32'h0000_0000
`endif

//--- prm_pkg.sv
// Types for the procedure return and miscellaneous instruction unit
package prm_pkg;
  typedef enum logic [1:0] {PRM_FLT_NONE, PRM_FLT_RSVD_OPND, PRM_FLT_RSVD_INSTR, PRM_FLT_PRIV} prm_fault_t;
  typedef struct packed {
    logic req;
    logic we;
    logic [3:0] idx;
    logic [31:0] wdata;
  } prm_rf_req_t;
  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } prm_mem_req_t;
endpackage : prm_pkg

//--- prm_core.sv
// Procedure return and miscellaneous instruction unit with APB control
`timescale 1ns/100ps
`include "prm_cfg.svh"
module prm_core (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output prm_pkg::prm_mem_req_t mem_req,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  output prm_pkg::prm_rf_req_t rf_req,
  input wire logic [31:0] rf_rdata,
  output logic halted
);
  import prm_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE, ST_EXEC, ST_RET_CTL, ST_RET_PC, ST_RET_FP, ST_RET_AP, ST_RET_REGS,
    ST_RET_CNT, ST_POP, ST_PUSH_RD, ST_PUSH_WR, ST_DONE
  } prm_state_t;

  prm_state_t state_ff, nxt_state;
  logic [31:0] psl_ff, sp_ff, fp_ff, ap_ff, pc_ff, result_ff, ctl_ff;
  logic [31:0] opa_ff, opb_ff, opc_ff, opd_ff, ope_ff;
  logic [7:0] opcode_ff;
  logic [15:0] scan_ff;
  logic [3:0] ridx_ff;
  logic busy_ff, done_ff, trap_ff;
  prm_fault_t fault_ff;
  logic [31:0] rd_ff, rdata_c;
  logic [31:0] idx_sum, idx_prod;
  logic bus_wr, bus_rd, mapped;

  // APB decode, zero wait state
  assign pready = 1'b1;
  assign bus_wr = psel & penable & pwrite;
  assign bus_rd = psel & ~pwrite;
  always_comb begin
    mapped = 1'b1;
    rdata_c = 32'h0000_0000;
    if (paddr == `PRM_REG_CMD) rdata_c = {24'h00_0000, opcode_ff};
    else if (paddr == `PRM_REG_OPA) rdata_c = opa_ff;
    else if (paddr == `PRM_REG_OPB) rdata_c = opb_ff;
    else if (paddr == `PRM_REG_OPC) rdata_c = opc_ff;
    else if (paddr == `PRM_REG_OPD) rdata_c = opd_ff;
    else if (paddr == `PRM_REG_OPE) rdata_c = ope_ff;
    else if (paddr == `PRM_REG_STATUS) rdata_c = {26'h000_0000, fault_ff, trap_ff, done_ff, busy_ff, halted};
    else if (paddr == `PRM_REG_RESULT) rdata_c = result_ff;
    else if (paddr == `PRM_REG_PSL) rdata_c = psl_ff;
    else if (paddr == `PRM_REG_SP) rdata_c = sp_ff;
    else if (paddr == `PRM_REG_FP) rdata_c = fp_ff;
    else if (paddr == `PRM_REG_AP) rdata_c = ap_ff;
    else if (paddr == `PRM_REG_PC) rdata_c = pc_ff;
    else mapped = 1'b0;
  end
  assign pslverr = psel & penable & ~mapped;
  assign prdata = rd_ff;

  // Read data register, loaded in setup phase
  always_ff @(posedge clk) begin
    if (!rst_n) rd_ff <= 32'h0000_0000;
    else if (bus_rd & ~penable) rd_ff <= rdata_c;
  end

  // Index arithmetic, wraps to 32 bits
  assign idx_sum = opa_ff + ope_ff;
  assign idx_prod = 32'(idx_sum * opd_ff);

  // Memory and register file requests
  always_comb begin
    mem_req = '0;
    rf_req = '0;
    case (state_ff)
      ST_RET_CTL, ST_RET_PC, ST_RET_FP, ST_RET_AP, ST_RET_CNT: begin
        mem_req.req = 1'b1;
        mem_req.addr = sp_ff;
      end
      ST_RET_REGS, ST_POP: begin
        mem_req.req = scan_ff[ridx_ff];
        mem_req.addr = sp_ff;
        rf_req.req = scan_ff[ridx_ff] & mem_ack;
        rf_req.we = 1'b1;
        rf_req.idx = ridx_ff;
        rf_req.wdata = mem_rdata;
      end
      ST_PUSH_RD: begin
        rf_req.req = scan_ff[ridx_ff];
        rf_req.idx = ridx_ff;
      end
      ST_PUSH_WR: begin
        mem_req.req = 1'b1;
        mem_req.we = 1'b1;
        mem_req.addr = sp_ff - `PRM_LONG_BYTES;
        mem_req.wdata = result_ff;
      end
      default: begin
      end
    endcase
  end

  // Sequencer next state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: if (bus_wr && paddr == `PRM_REG_CMD && !halted) nxt_state = ST_EXEC;
      ST_EXEC: begin
        if (opcode_ff == `PRM_OP_RETURN) nxt_state = ST_RET_CTL;
        else if (opcode_ff == `PRM_OP_RPOP) nxt_state = ST_POP;
        else if (opcode_ff == `PRM_OP_RPUSH) nxt_state = ST_PUSH_RD;
        else nxt_state = ST_DONE;
      end
      ST_RET_CTL: if (mem_ack) nxt_state = (mem_rdata[15:8] != 8'h00) ? ST_DONE : ST_RET_PC;
      ST_RET_PC: if (mem_ack) nxt_state = ST_RET_FP;
      ST_RET_FP: if (mem_ack) nxt_state = ST_RET_AP;
      ST_RET_AP: if (mem_ack) nxt_state = ST_RET_REGS;
      ST_RET_REGS: if ((mem_ack || !scan_ff[ridx_ff]) && ridx_ff == 4'hB)
        nxt_state = ctl_ff[29] ? ST_RET_CNT : ST_DONE;
      ST_RET_CNT: if (mem_ack) nxt_state = ST_DONE;
      ST_POP: if ((mem_ack || !scan_ff[ridx_ff]) && ridx_ff == `PRM_SP_IDX) nxt_state = ST_DONE;
      ST_PUSH_RD: begin
        if (scan_ff[ridx_ff]) nxt_state = ST_PUSH_WR;
        else if (ridx_ff == 4'h0) nxt_state = ST_DONE;
      end
      ST_PUSH_WR: if (mem_ack) nxt_state = (ridx_ff == 4'h0) ? ST_DONE : ST_PUSH_RD;
      ST_DONE: nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) state_ff <= ST_IDLE;
    else state_ff <= nxt_state;
  end

  // Operand and command registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      opcode_ff <= 8'h01;
      opa_ff <= 32'h0000_0000;
      opb_ff <= 32'h0000_0000;
      opc_ff <= 32'h0000_0000;
      opd_ff <= 32'h0000_0000;
      ope_ff <= 32'h0000_0000;
    end else if (bus_wr && state_ff == ST_IDLE) begin
      if (paddr == `PRM_REG_CMD) opcode_ff <= pwdata[7:0];
      else if (paddr == `PRM_REG_OPA) opa_ff <= pwdata;
      else if (paddr == `PRM_REG_OPB) opb_ff <= pwdata;
      else if (paddr == `PRM_REG_OPC) opc_ff <= pwdata;
      else if (paddr == `PRM_REG_OPD) opd_ff <= pwdata;
      else if (paddr == `PRM_REG_OPE) ope_ff <= pwdata;
    end
  end

  // Status flags: busy, done, fault, trap, halt
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      trap_ff <= 1'b0;
      fault_ff <= PRM_FLT_NONE;
      halted <= 1'b0;
    end else if (state_ff == ST_IDLE && nxt_state == ST_EXEC) begin
      busy_ff <= 1'b1;
      done_ff <= 1'b0;
      trap_ff <= 1'b0;
      fault_ff <= PRM_FLT_NONE;
    end else if (state_ff == ST_EXEC) begin
      if (opcode_ff == `PRM_OP_SBSET || opcode_ff == `PRM_OP_SBCLR) begin
        if (opa_ff[15:8] != 8'h00) fault_ff <= PRM_FLT_RSVD_OPND;
      end else if (opcode_ff == `PRM_OP_BRK) trap_ff <= 1'b1;
      else if (opcode_ff == `PRM_OP_BUG_LO || opcode_ff == `PRM_OP_BUG_LO2 || opcode_ff == `PRM_OP_BUG_HI)
        fault_ff <= PRM_FLT_RSVD_INSTR;
      else if (opcode_ff == `PRM_OP_HALT) begin
        if (psl_ff[25:24] == `PRM_KERNEL_MODE) halted <= 1'b1;
        else fault_ff <= PRM_FLT_PRIV;
      end else if (opcode_ff == `PRM_OP_INDEX) begin
        if ($signed(opa_ff) < $signed(opb_ff) || $signed(opa_ff) > $signed(opc_ff)) trap_ff <= 1'b1;
      end
    end else if (state_ff == ST_RET_CTL && mem_ack && mem_rdata[15:8] != 8'h00) begin
      fault_ff <= PRM_FLT_RSVD_OPND;
    end else if (state_ff == ST_DONE) begin
      busy_ff <= 1'b0;
      done_ff <= 1'b1;
    end
  end

  // Result register: index out, status longword, push data
  always_ff @(posedge clk) begin
    if (!rst_n) result_ff <= 32'h0000_0000;
    else if (state_ff == ST_EXEC && opcode_ff == `PRM_OP_INDEX) result_ff <= idx_prod;
    else if (state_ff == ST_EXEC && opcode_ff == `PRM_OP_RDPSL) result_ff <= psl_ff;
    else if (state_ff == ST_PUSH_RD && scan_ff[ridx_ff]) result_ff <= rf_rdata;
  end

  // Scan mask and register index
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scan_ff <= 16'h0000;
      ridx_ff <= 4'h0;
    end else if (state_ff == ST_EXEC) begin
      scan_ff <= {1'b0, opa_ff[14:0]};
      ridx_ff <= (opcode_ff == `PRM_OP_RPUSH) ? `PRM_SP_IDX : 4'h0;
    end else if (state_ff == ST_RET_CTL && mem_ack) begin
      scan_ff <= {4'h0, mem_rdata[27:16]};
      ridx_ff <= 4'h0;
    end else if ((state_ff == ST_RET_REGS || state_ff == ST_POP) && (mem_ack || !scan_ff[ridx_ff])) begin
      ridx_ff <= ridx_ff + 4'h1;
    end else if ((state_ff == ST_PUSH_RD && !scan_ff[ridx_ff]) || (state_ff == ST_PUSH_WR && mem_ack)) begin
      ridx_ff <= ridx_ff - 4'h1;
    end
  end

  // Saved control longword, bit 28 never consulted
  always_ff @(posedge clk) begin
    if (!rst_n) ctl_ff <= 32'h0000_0000;
    else if (state_ff == ST_RET_CTL && mem_ack) ctl_ff <= mem_rdata;
  end

  // Stack, frame, argument pointers and program counter
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sp_ff <= 32'h0000_0000;
      fp_ff <= 32'h0000_0000;
      ap_ff <= 32'h0000_0000;
      pc_ff <= 32'h0000_0000;
    end else if (bus_wr && state_ff == ST_IDLE && paddr == `PRM_REG_SP) sp_ff <= pwdata;
    else if (bus_wr && state_ff == ST_IDLE && paddr == `PRM_REG_FP) fp_ff <= pwdata;
    else if (bus_wr && state_ff == ST_IDLE && paddr == `PRM_REG_AP) ap_ff <= pwdata;
    else if (bus_wr && state_ff == ST_IDLE && paddr == `PRM_REG_PC) pc_ff <= pwdata;
    else begin
      case (state_ff)
        ST_EXEC: begin
          if (opcode_ff == `PRM_OP_RETURN) sp_ff <= fp_ff + `PRM_FRAME_OFS;
          else if (fault_ff == PRM_FLT_NONE) pc_ff <= pc_ff + 32'h0000_0001;
        end
        ST_RET_CTL, ST_RET_PC, ST_RET_FP, ST_RET_AP: if (mem_ack) begin
          sp_ff <= sp_ff + `PRM_LONG_BYTES;
          if (state_ff == ST_RET_PC) pc_ff <= mem_rdata;
          if (state_ff == ST_RET_FP) fp_ff <= mem_rdata;
          if (state_ff == ST_RET_AP) ap_ff <= mem_rdata;
        end
        ST_RET_REGS: begin
          if (ridx_ff == 4'hB && (mem_ack || !scan_ff[ridx_ff]))
            sp_ff <= sp_ff + ((mem_ack && scan_ff[ridx_ff]) ? `PRM_LONG_BYTES : 32'h0) + {30'h0, ctl_ff[31:30]};
          else if (mem_ack && scan_ff[ridx_ff]) sp_ff <= sp_ff + `PRM_LONG_BYTES;
        end
        ST_RET_CNT: if (mem_ack) sp_ff <= sp_ff + `PRM_LONG_BYTES + {22'h0, mem_rdata[7:0], 2'b00};
        ST_POP: if (mem_ack && scan_ff[ridx_ff]) sp_ff <= sp_ff + `PRM_LONG_BYTES;
        ST_PUSH_WR: if (mem_ack) sp_ff <= sp_ff - `PRM_LONG_BYTES;
        default: begin
        end
      endcase
    end
  end

  // Processor status longword updates
  always_ff @(posedge clk) begin
    if (!rst_n) psl_ff <= `PRM_PSL_RST;
    else if (bus_wr && state_ff == ST_IDLE && paddr == `PRM_REG_PSL) psl_ff <= pwdata;
    else if (state_ff == ST_EXEC) begin
      if (opcode_ff == `PRM_OP_SBCLR && opa_ff[15:8] == 8'h00)
        psl_ff[15:0] <= psl_ff[15:0] & ~opa_ff[15:0];
      else if (opcode_ff == `PRM_OP_SBSET && opa_ff[15:8] == 8'h00)
        psl_ff[15:0] <= psl_ff[15:0] | opa_ff[15:0];
      else if (opcode_ff == `PRM_OP_BRK) begin
        psl_ff[30] <= 1'b0;
        psl_ff[3:0] <= 4'h0;
      end else if (opcode_ff == `PRM_OP_HALT && psl_ff[25:24] != `PRM_KERNEL_MODE)
        psl_ff[3:0] <= 4'h0;
    end else if (state_ff == ST_RET_CTL && mem_ack && mem_rdata[15:8] == 8'h00)
      psl_ff[15:0] <= mem_rdata[15:0];
  end

  // Guards
  a_ret_sp_frame: assert property (@(posedge clk) disable iff (!rst_n)
    state_ff == ST_EXEC && opcode_ff == `PRM_OP_RETURN |=> sp_ff == $past(fp_ff) + 32'h4)
    else $error("return stack pointer not frame plus four");
  a_sbit_fault_keep: assert property (@(posedge clk) disable iff (!rst_n)
    state_ff == ST_EXEC && (opcode_ff == `PRM_OP_SBSET || opcode_ff == `PRM_OP_SBCLR) && opa_ff[15:8] != 8'h00
    |=> $stable(psl_ff) && fault_ff == PRM_FLT_RSVD_OPND)
    else $error("status word changed on faulting set");
  a_sbit_clear: assert property (@(posedge clk) disable iff (!rst_n)
    state_ff == ST_EXEC && opcode_ff == `PRM_OP_SBCLR && opa_ff[15:8] == 8'h00 |=> (psl_ff[15:0] & $past(opa_ff[15:0])) == 16'h0)
    else $error("status clear left bits set");
  a_sbit_set: assert property (@(posedge clk) disable iff (!rst_n)
    state_ff == ST_EXEC && opcode_ff == `PRM_OP_SBSET && opa_ff[15:8] == 8'h00 |=> (psl_ff[15:0] & $past(opa_ff[15:0])) == $past(opa_ff[15:0]))
    else $error("status set missed bits");
  a_brk_clears: assert property (@(posedge clk) disable iff (!rst_n)
    state_ff == ST_EXEC && opcode_ff == `PRM_OP_BRK |=> psl_ff[30] == 1'b0 && psl_ff[3:0] == 4'h0 && trap_ff)
    else $error("breakpoint effects missing");
  a_bug_fault: assert property (@(posedge clk) disable iff (!rst_n)
    state_ff == ST_EXEC && (opcode_ff == `PRM_OP_BUG_LO || opcode_ff == `PRM_OP_BUG_LO2 || opcode_ff == `PRM_OP_BUG_HI)
    |=> fault_ff == PRM_FLT_RSVD_INSTR && $stable(psl_ff[3:0]))
    else $error("bugcheck did not fault cleanly");
  a_halt_kernel: assert property (@(posedge clk) disable iff (!rst_n)
    state_ff == ST_EXEC && opcode_ff == `PRM_OP_HALT && psl_ff[25:24] == 2'h0 |=> halted && $stable(psl_ff))
    else $error("kernel halt failed");
  a_index_value: assert property (@(posedge clk) disable iff (!rst_n)
    state_ff == ST_EXEC && opcode_ff == `PRM_OP_INDEX |=> result_ff == 32'(($past(opa_ff) + $past(ope_ff)) * $past(opd_ff)))
    else $error("index result wrong");
  a_rdpsl_copy: assert property (@(posedge clk) disable iff (!rst_n)
    state_ff == ST_EXEC && opcode_ff == `PRM_OP_RDPSL |=> result_ff == $past(psl_ff) && $stable(psl_ff))
    else $error("status longword copy wrong");
  a_ret_psw: assert property (@(posedge clk) disable iff (!rst_n)
    state_ff == ST_RET_CTL && mem_ack && mem_rdata[15:8] == 8'h00 |=> psl_ff[3:0] == $past(mem_rdata[3:0]))
    else $error("return status word not restored");
  a_ret_fault: assert property (@(posedge clk) disable iff (!rst_n)
    state_ff == ST_RET_CTL && mem_ack && mem_rdata[15:8] != 8'h00 |=> fault_ff == PRM_FLT_RSVD_OPND ##1 !busy_ff)
    else $error("return reserved operand fault missing");
  a_push_down: assert property (@(posedge clk) disable iff (!rst_n)
    state_ff == ST_PUSH_WR && mem_ack |=> sp_ff == $past(sp_ff) - 32'h4)
    else $error("push did not step stack down");
  a_nop_pc: assert property (@(posedge clk) disable iff (!rst_n)
    state_ff == ST_EXEC && opcode_ff == `PRM_OP_NOP |=> pc_ff == $past(pc_ff) + 32'h1 && $stable(psl_ff) && $stable(sp_ff))
    else $error("no-operation altered state");
endmodule : prm_core

//--- tb.sv
// Self-checking bench for the procedure return and miscellaneous unit
`timescale 1ns/100ps
`include "prm_cfg.svh"
`define TB_CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin failures++; $display("[ERR] %0t value mismatch got %h exp %h", $time, got, exp); end end
module tb;
  import prm_pkg::*;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, mem_ack, halted;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, mem_rdata, rf_rdata, rd_v, psl_v, m, a, b, c, d, e, f, ctl, exp_v;
  prm_mem_req_t mem_req;
  prm_rf_req_t rf_req;
  logic [31:0] mem [logic [31:0]];
  logic [31:0] rf [16];
  logic [31:0] keep [16];
  logic [64:0] q [$];
  logic [64:0] ent;
  logic [7:0] bug_ops [3] = '{`PRM_OP_BUG_LO, `PRM_OP_BUG_LO2, `PRM_OP_BUG_HI};
  int failures, n_tests;

  prm_core i_prm_core (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_req(mem_req), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .rf_req(rf_req),
    .rf_rdata(rf_rdata), .halted(halted));

  // Clock at 100 MHz
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Stack memory with random answer delay, data scrambled outside an answer
  always @(posedge clk) begin
    if (mem_ack) begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req.we) mem[mem_req.addr] = mem_req.wdata;
    end else if (mem_req.req && $urandom_range(0, 1)) begin
      mem_ack <= 1'b1;
      mem_rdata <= mem[mem_req.addr];
    end else begin
      mem_rdata <= ~mem_rdata;
    end
  end

  // Register file, combinational read
  always @(posedge clk) begin
    if (rf_req.req && rf_req.we) rf[rf_req.idx] <= rf_req.wdata;
  end
  assign rf_rdata = rf[rf_req.idx];

  // Read watcher: oldest note against each completed read
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite && q.size() > 0) begin
      ent = q.pop_front();
      `TB_CHK({pslverr, prdata & ent[63:32]}, {ent[64], ent[31:0] & ent[63:32]})
    end
  end

  task stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  // One APB transfer, held until pready is seen high
  task apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (n >= 100) begin
      failures++;
      $display("[ERR] %0t bus answer timeout", $time);
      stop_test();
    end
    rd_v = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task wr(input logic [11:0] ad, input logic [31:0] wd);
    apb(1'b1, ad, wd);
  endtask : wr

  task rd(input logic [11:0] ad, input logic [31:0] msk, input logic [31:0] ex, input logic er = 1'b0);
    q.push_back({er, msk, ex});
    apb(1'b0, ad, 32'h0000_0000);
  endtask : rd

  // Start an instruction, wait until idle, then check status bits under msk
  task run(input logic [7:0] op, input logic [31:0] msk, input logic [31:0] st);
    int n;
    wr(`PRM_REG_CMD, {24'h00_0000, op});
    n = 0;
    do begin
      rd(`PRM_REG_STATUS, 32'h0000_0000, 32'h0000_0000);
      n++;
    end while (rd_v[1] !== 1'b0 && n < 200);
    if (n >= 200) begin
      failures++;
      $display("[ERR] %0t instruction timeout", $time);
      stop_test();
    end
    rd(`PRM_REG_STATUS, msk, st);
  endtask : run

  task tend(input string s);
    $display("test %s finished", s);
  endtask : tend

  // Watchdog
  initial begin
    #1000000;
    failures++;
    $display("[ERR] %0t run timeout", $time);
    stop_test();
  end

  initial begin
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0000_0000;
    mem_ack = 1'b0; mem_rdata = 32'h0000_0000; rst_n = 1'b0; failures = 0; n_tests = 0;
    void'($urandom(59408));
    for (int i = 0; i < 16; i++) rf[i] = $urandom;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(`PRM_REG_PSL, 32'hFFFF_FFFF, `PRM_PSL_RST);
    rd(`PRM_REG_STATUS, 32'h0000_003F, 32'h0000_0000);
    rd(12'h0FC, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1);
    tend("reset");
    // Status set then clear, then refused masks on both
    for (int k = 0; k < 4; k++) begin
      psl_v = {24'h00_0000, 8'($urandom)};
      m = {24'h00_0000, 8'($urandom)};
      wr(`PRM_REG_PSL, psl_v);
      wr(`PRM_REG_OPA, m);
      run(`PRM_OP_SBSET, 32'h0000_0030, 32'h0000_0000);
      rd(`PRM_REG_PSL, 32'h0000_FFFF, psl_v | m);
      run(`PRM_OP_SBCLR, 32'h0000_0030, 32'h0000_0000);
      rd(`PRM_REG_PSL, 32'h0000_FFFF, psl_v & ~m);
      wr(`PRM_REG_OPA, m | {16'h0000, 8'($urandom_range(1, 255)), 8'h00});
      run((k % 2) ? `PRM_OP_SBSET : `PRM_OP_SBCLR, 32'h0000_0030, 32'h0000_0010);
      rd(`PRM_REG_PSL, 32'hFFFF_FFFF, psl_v & ~m);
    end
    tend("status bits");
    // Read status longword and no-operation
    psl_v = $urandom & 32'hFCFF_FFFF;
    a = $urandom;
    b = $urandom;
    wr(`PRM_REG_PSL, psl_v);
    run(`PRM_OP_RDPSL, 32'h0000_0030, 32'h0000_0000);
    rd(`PRM_REG_RESULT, 32'hFFFF_FFFF, psl_v);
    rd(`PRM_REG_PSL, 32'hFFFF_FFFF, psl_v);
    wr(`PRM_REG_PC, a);
    wr(`PRM_REG_SP, b);
    run(`PRM_OP_NOP, 32'h0000_0038, 32'h0000_0000);
    rd(`PRM_REG_PC, 32'hFFFF_FFFF, a + 32'h0000_0001);
    rd(`PRM_REG_SP, 32'hFFFF_FFFF, b);
    rd(`PRM_REG_PSL, 32'hFFFF_FFFF, psl_v);
    tend("status read and no-op");
    // Index: in range, below and above bounds, large values wrap
    for (int k = 0; k < 3; k++) begin
      b = $urandom_range(0, 100);
      c = b + 32'h0000_0032;
      a = (k == 0) ? b + $urandom_range(0, 50) : (k == 1) ? b - 32'h0000_0001 : c + 32'h0000_0001;
      d = $urandom;
      e = $urandom;
      wr(`PRM_REG_OPA, a);
      wr(`PRM_REG_OPB, b);
      wr(`PRM_REG_OPC, c);
      wr(`PRM_REG_OPD, d);
      wr(`PRM_REG_OPE, e);
      run(`PRM_OP_INDEX, 32'h0000_0038, (k == 0) ? 32'h0000_0000 : 32'h0000_0008);
      rd(`PRM_REG_RESULT, 32'hFFFF_FFFF, (e + a) * d);
    end
    tend("index");
    // Masked push then pop with bit 15 set
    m = {16'h0000, 1'b1, 15'($urandom)};
    wr(`PRM_REG_SP, 32'h0000_8000);
    wr(`PRM_REG_OPA, m);
    run(`PRM_OP_RPUSH, 32'h0000_0038, 32'h0000_0000);
    exp_v = 32'h0000_8000;
    for (int i = 14; i >= 0; i--) begin
      if (m[i]) begin
        exp_v = exp_v - 32'h0000_0004;
        `TB_CHK(mem[exp_v], rf[i])
      end
    end
    rd(`PRM_REG_SP, 32'hFFFF_FFFF, exp_v);
    keep = rf;
    for (int i = 0; i < 16; i++) rf[i] = ~keep[i];
    run(`PRM_OP_RPOP, 32'h0000_0038, 32'h0000_0000);
    for (int i = 0; i < 16; i++) `TB_CHK(rf[i], (i < 15 && m[i]) ? keep[i] : ~keep[i])
    rd(`PRM_REG_SP, 32'hFFFF_FFFF, 32'h0000_8000);
    tend("register push and pop");
    // Procedure return, with and without argument list, then refused frame
    for (int k = 0; k < 2; k++) begin
      f = 32'h0000_4000;
      ctl = {2'($urandom), k[0], ~k[0], 12'($urandom), 8'h00, 8'($urandom)};
      a = $urandom;
      b = $urandom;
      c = $urandom;
      mem[f + 32'h0000_0004] = ctl;
      mem[f + 32'h0000_0008] = a;
      mem[f + 32'h0000_000C] = b;
      mem[f + 32'h0000_0010] = c;
      exp_v = f + 32'h0000_0014;
      keep = rf;
      for (int i = 0; i < 12; i++) begin
        if (ctl[16 + i]) begin
          keep[i] = $urandom;
          mem[exp_v] = keep[i];
          exp_v = exp_v + 32'h0000_0004;
        end
      end
      exp_v = exp_v + {30'h0, ctl[31:30]};
      d = $urandom;
      if (ctl[29]) begin
        mem[exp_v] = d;
        exp_v = exp_v + 32'h0000_0004 + {22'h0, d[7:0], 2'b00};
      end
      wr(`PRM_REG_FP, f);
      wr(`PRM_REG_PSL, 32'h0000_0000);
      run(`PRM_OP_RETURN, 32'h0000_0030, 32'h0000_0000);
      rd(`PRM_REG_PC, 32'hFFFF_FFFF, a);
      rd(`PRM_REG_FP, 32'hFFFF_FFFF, b);
      rd(`PRM_REG_AP, 32'hFFFF_FFFF, c);
      rd(`PRM_REG_SP, 32'hFFFF_FFFF, exp_v);
      rd(`PRM_REG_PSL, 32'h0000_FFFF, {16'h0000, ctl[15:0]});
      rd(`PRM_REG_PSL, 32'h0000_000F, {28'h0, ctl[3:0]});
      for (int i = 0; i < 16; i++) `TB_CHK(rf[i], keep[i])
    end
    mem[f + 32'h0000_0004] = ctl | 32'h0000_0100;
    wr(`PRM_REG_FP, f);
    run(`PRM_OP_RETURN, 32'h0000_0030, 32'h0000_0010);
    tend("procedure return");
    // Breakpoint and bugcheck opcodes
    wr(`PRM_REG_PSL, 32'h4000_000F);
    run(`PRM_OP_BRK, 32'h0000_0038, 32'h0000_0008);
    rd(`PRM_REG_PSL, 32'h4000_000F, 32'h0000_0000);
    for (int k = 0; k < 3; k++) begin
      wr(`PRM_REG_PSL, 32'h0000_000A);
      run(bug_ops[k], 32'h0000_0030, 32'h0000_0020);
      rd(`PRM_REG_PSL, 32'h0000_000F, 32'h0000_000A);
    end
    tend("breakpoint and bugcheck");
    // Halt outside kernel faults, in kernel stops
    wr(`PRM_REG_PSL, 32'h0300_0007);
    run(`PRM_OP_HALT, 32'h0000_0031, 32'h0000_0030);
    rd(`PRM_REG_PSL, 32'h0000_000F, 32'h0000_0000);
    `TB_CHK(halted, 1'b0)
    wr(`PRM_REG_PSL, 32'h0000_0009);
    run(`PRM_OP_HALT, 32'h0000_0031, 32'h0000_0001);
    rd(`PRM_REG_PSL, 32'h0000_000F, 32'h0000_0009);
    `TB_CHK(halted, 1'b1)
    tend("halt");
    stop_test();
  end
endmodule : tb
